//--- rtl/utg_top.sv
`timescale 1ns/1ps
module utg_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire utg_pkg::utg_reg_req_t regReq,
  output logic [31:0] regRdata,
  // Transmit holding side
  input wire logic txHoldValid,
  input wire logic [7:0] txHoldData,
  output logic txHoldTake,
  // Transmit shift register side
  input wire logic txShiftBusy,
  output logic txShiftLoad,
  output logic [7:0] txShiftData,
  // Received characters
  input wire logic rxValid,
  input wire utg_pkg::utg_rx_char_t rxChar,
  // Receive FIFO write and events
  output logic rxFifoWrite,
  output utg_pkg::utg_rx_char_t rxFifoData,
  output logic rxDataReadyEvent,
  output logic addressEvent,
  // Mode view
  output logic transmitPermit,
  output logic [2:0] multidropCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  logic transmitPermit_reg; // Transmit permit bit
  logic multidropEnable_reg; // Multidrop mode on
  logic receiveInhibit_reg; // Receiver disabled
  logic autoAddressEnable_reg; // Automatic address detect on
  logic [7:0] addressMatch_reg; // Slave address
  // Filter decisions for the character now on rxChar
  logic storeChar; // Push to the receive FIFO
  logic setInhibit; // Mismatched address shuts the receiver
  logic clearInhibit; // Matched address opens the receiver
  logic addressSeen; // Address character in multidrop mode
  // Register write strobes, one per mapped address
  logic wrPermit;
  logic wrMulti;
  logic wrMatch;

  // Write decode
  // Exact address match only; unmapped writes fall through unused
  assign wrPermit = regReq.wrEn && (regReq.addr == utg_pkg::TX_PERMIT_CTRL_ADDR);
  assign wrMulti = regReq.wrEn && (regReq.addr == utg_pkg::MULTIDROP_CTRL_ADDR);
  assign wrMatch = regReq.wrEn && (regReq.addr == utg_pkg::ADDR_MATCH_ADDR);

  // Transmit permit register; software handles flow control
  // Clearing it only stops new loads; the shifter is never aborted
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transmitPermit_reg <= utg_pkg::RESET_TRANSMIT_PERMIT;
    end else if (wrPermit) begin
      // Reserved bits are dropped on write
      transmitPermit_reg <= regReq.wdata[utg_pkg::TRANSMIT_PERMIT_BIT];
    end
  end

  // Mode bits written by software
  // Reset values come from the package so the mode views and registers agree
  // Auto address only acts together with multidrop enable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      multidropEnable_reg <= utg_pkg::RESET_MULTIDROP_CTRL[0];
      autoAddressEnable_reg <= utg_pkg::RESET_MULTIDROP_CTRL[2];
    end else if (wrMulti) begin
      multidropEnable_reg <= regReq.wdata[utg_pkg::MULTIDROP_ENABLE_BIT];
      autoAddressEnable_reg <= regReq.wdata[utg_pkg::AUTO_ADDRESS_ENABLE_BIT];
    end
  end

  // Receive inhibit: hardware update wins over a software write,
  // so a set or clear is never lost, but a mismatch while already inhibited raises no set and a racing write wins;
  // set and clear cannot both come from one character
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      receiveInhibit_reg <= utg_pkg::RESET_MULTIDROP_CTRL[1];
    end else if (setInhibit) begin
      receiveInhibit_reg <= 1'b1;
    end else if (clearInhibit) begin
      receiveInhibit_reg <= 1'b0;
    end else if (wrMulti) begin
      receiveInhibit_reg <= regReq.wdata[utg_pkg::RECEIVE_INHIBIT_BIT];
    end
  end

  // Address match value
  // Only the low byte exists; upper write bits are dropped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addressMatch_reg <= utg_pkg::RESET_ADDRESS_MATCH;
    end else if (wrMatch) begin
      addressMatch_reg <= regReq.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, registered one cycle after rdEn
  // Read data holds until the next read, so a slow master may sample late

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h0000_0000;
    end else if (regReq.rdEn) begin
      // Reserved bits read as zero
      unique case (regReq.addr)
        utg_pkg::TX_PERMIT_CTRL_ADDR: begin
          regRdata <= {24'h00_0000, transmitPermit_reg, 7'h00};
        end
        utg_pkg::MULTIDROP_CTRL_ADDR: begin
          regRdata <= {29'h0000_0000, autoAddressEnable_reg, receiveInhibit_reg,
                       multidropEnable_reg};
        end
        utg_pkg::ADDR_MATCH_ADDR: begin
          regRdata <= {24'h00_0000, addressMatch_reg};
        end
        default: begin // Unmapped addresses read as zero
          regRdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit gate

  // A transfer starts only when permitted and the shifter is idle.
  // txShiftLoad holds one cycle, so busy must rise by the next cycle;
  // the pending load also blocks a second take in that gap.
  // The gate never touches a character already in the shifter.
  // Trade-off: one idle cycle between loads costs little against a
  // character time and spares the shifter a combinational busy flag.
  // The holding buffer must show its next character a cycle after the pop.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txHoldTake <= 1'b0;
      txShiftLoad <= 1'b0;
      txShiftData <= 8'h00;
    end else begin
      // Pulses by default; raised only for a granted transfer
      txHoldTake <= 1'b0;
      txShiftLoad <= 1'b0;
      if (transmitPermit_reg && txHoldValid && !txShiftBusy
          && !txShiftLoad && !txHoldTake) begin
        txHoldTake <= 1'b1;
        txShiftLoad <= 1'b1;
        txShiftData <= txHoldData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path

  // The filter is pure logic; its decision is registered below
  utg_rx_filter rxFilter (
    .multidropEnable(multidropEnable_reg),
    .autoAddressEnable(autoAddressEnable_reg),
    .receiveInhibit(receiveInhibit_reg),
    .addressMatchValue(addressMatch_reg),
    .rxValid(rxValid),
    .rxChar(rxChar),
    .storeChar(storeChar),
    .setInhibit(setInhibit),
    .clearInhibit(clearInhibit),
    .addressSeen(addressSeen)
  );

  // FIFO write and event pulses, one cycle after the character
  // One pulse per stored character; the FIFO itself lives outside
  // The data register moves only on a store, so it keeps the last one
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rxFifoWrite <= 1'b0;
      rxFifoData <= '0;
      rxDataReadyEvent <= 1'b0;
      addressEvent <= 1'b0;
    end else begin
      // Store and ready event travel together
      rxFifoWrite <= storeChar;
      rxDataReadyEvent <= storeChar;
      // Parity-error style address flag in multidrop mode
      addressEvent <= addressSeen;
      if (storeChar) begin
        rxFifoData <= rxChar;
      end
    end
  end

  // Mode view outputs
  // Views lag the registers by one cycle, keeping every output a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transmitPermit <= utg_pkg::RESET_TRANSMIT_PERMIT;
      multidropCtrl <= utg_pkg::RESET_MULTIDROP_CTRL;
    end else begin
      // Copies only; nothing reads these views inside the block
      transmitPermit <= transmitPermit_reg;
      multidropCtrl <= {autoAddressEnable_reg, receiveInhibit_reg, multidropEnable_reg};
    end
  end

endmodule

//--- rtl/utg_pkg.sv
package utg_pkg;

  // Register byte addresses
  localparam logic [31:0] TX_PERMIT_CTRL_ADDR = 32'h4000_8030;
  localparam logic [31:0] MULTIDROP_CTRL_ADDR = 32'h4000_804C;
  localparam logic [31:0] ADDR_MATCH_ADDR = 32'h4000_8050;

  // Field positions
  localparam int TRANSMIT_PERMIT_BIT = 7;
  localparam int MULTIDROP_ENABLE_BIT = 0;
  localparam int RECEIVE_INHIBIT_BIT = 1;
  localparam int AUTO_ADDRESS_ENABLE_BIT = 2;

  // Reset values
  localparam logic RESET_TRANSMIT_PERMIT = 1'b1;
  localparam logic [2:0] RESET_MULTIDROP_CTRL = 3'h0;
  localparam logic [7:0] RESET_ADDRESS_MATCH = 8'h00;

  // Received character with its ninth (parity) bit
  typedef struct packed {
    logic parityBit;
    logic [7:0] data;
  } utg_rx_char_t;

  // Register bus request
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [31:0] addr;
    logic [31:0] wdata;
  } utg_reg_req_t;

endpackage

//--- rtl/utg_rx_filter.sv
`timescale 1ns/1ps
// Decides the fate of one received character under the multidrop modes
module utg_rx_filter (
  // Mode
  input wire logic multidropEnable,
  input wire logic autoAddressEnable,
  input wire logic receiveInhibit,
  input wire logic [7:0] addressMatchValue,
  // Character
  input wire logic rxValid,
  input wire utg_pkg::utg_rx_char_t rxChar,
  // Decision
  output logic storeChar,
  output logic setInhibit,
  output logic clearInhibit,
  output logic addressSeen
);

  logic isAddress;
  logic isMatch;
  logic autoMode;

  // Address characters carry a parity bit of one
  assign isAddress = rxValid && multidropEnable && rxChar.parityBit;
  assign isMatch = (rxChar.data == addressMatchValue);
  assign autoMode = multidropEnable && autoAddressEnable;

  // Storage and inhibit decision
  always_comb begin
    storeChar = 1'b0;
    setInhibit = 1'b0;
    clearInhibit = 1'b0;
    addressSeen = isAddress;
    if (!rxValid) begin
      storeChar = 1'b0;
    end else if (!multidropEnable) begin
      // Plain UART: keep all, inhibit still honoured
      storeChar = !receiveInhibit;
    end else if (autoMode) begin
      if (isAddress && isMatch) begin
        storeChar = 1'b1;
        clearInhibit = 1'b1;
      end else if (isAddress) begin
        storeChar = 1'b0;
        setInhibit = !receiveInhibit;
      end else begin
        storeChar = !receiveInhibit;
      end
    end else begin
      // Normal multidrop: addresses always pass
      storeChar = isAddress || !receiveInhibit;
    end
  end

endmodule

//--- verif/utg_monitor.sv
`timescale 1ns/1ps
// Ties gate and receive outputs to their causes at the inputs
module utg_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Transmit side
  input wire logic txHoldValid,
  input wire logic [7:0] txHoldData,
  input wire logic txHoldTake,
  input wire logic txShiftBusy,
  input wire logic txShiftLoad,
  input wire logic [7:0] txShiftData,
  input wire logic transmitPermit,
  // Receive side
  input wire logic rxValid,
  input wire utg_pkg::utg_rx_char_t rxChar,
  input wire logic rxFifoWrite,
  input wire utg_pkg::utg_rx_char_t rxFifoData,
  input wire logic rxDataReadyEvent,
  input wire logic addressEvent,
  input wire logic [2:0] multidropCtrl
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_RESET_VIEW: assert property ($rose(rstn) |-> transmitPermit && !multidropCtrl)
    else $error("mode view not at reset values");
  // Permit view lags by one, so it lines up with the load it allowed
  AST_GATE_SHUT: assert property (txShiftLoad |-> transmitPermit)
    else $error("load while permit low");
  AST_LOAD_DATA: assert property (txShiftLoad |-> txHoldTake && txShiftData == $past(txHoldData))
    else $error("load data or pop wrong");
  AST_LOAD_CAUSE: assert property (txShiftLoad |-> $past(txHoldValid) && !$past(txShiftBusy))
    else $error("load without cause");
  AST_LOAD_GAP: assert property (txShiftLoad |=> !txShiftLoad)
    else $error("loads back to back");
  AST_RX_CAUSE: assert property (rxFifoWrite |-> $past(rxValid) && rxFifoData == $past(rxChar))
    else $error("stored character wrong");
  AST_READY_EVT: assert property (rxDataReadyEvent == rxFifoWrite)
    else $error("ready event apart from store");
  AST_ADDR_CAUSE: assert property (addressEvent |-> $past(rxValid) && $past(rxChar.parityBit))
    else $error("address event without address");
endmodule

//--- verif/utg_shifter_model.sv
`timescale 1ns/1ps
// Transmit shift register: busy for a few cycles per character
module utg_shifter_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Load side
  input wire logic txShiftLoad,
  input wire logic [7:0] txShiftData,
  input wire logic slow,
  // Shifter state and log of sent characters
  output logic txShiftBusy,
  output logic [31:0] sentWord,
  output logic [3:0] sentCount
);
  logic [3:0] bitCnt; // Cycles left in this character
  ////////////////////////////////////////////////////////////////////////////////
  // Busy rises one edge after the load; the gate's own load flag covers that gap
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {txShiftBusy, sentWord, sentCount, bitCnt} <= '0;
    end else if (txShiftLoad) begin
      bitCnt <= slow ? 4'hB : 4'h2;
      txShiftBusy <= 1'b1;
      sentWord <= {sentWord[23:0], txShiftData};
      sentCount <= sentCount + 4'h1;
    end else if (bitCnt != 4'h0) begin
      bitCnt <= bitCnt - 4'h1;
    end else begin
      txShiftBusy <= 1'b0; // Character always finishes once started
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  // Design ports
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  utg_pkg::utg_reg_req_t regReq = '0;
  logic rxValid = 1'b0;
  utg_pkg::utg_rx_char_t rxChar = '0;
  utg_pkg::utg_rx_char_t rxFifoData;
  logic [31:0] regRdata, sentWord;
  logic [7:0] txShiftData;
  logic [3:0] sentCount;
  logic [2:0] multidropCtrl;
  logic txHoldTake, txShiftBusy, txShiftLoad, rxFifoWrite, rxDataReadyEvent;
  logic addressEvent, transmitPermit;
  logic slow = 1'b0; // Shifter speed
  // Holding buffer contents; hCnt is how many have been queued so far
  logic [7:0] hold [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int hIdx = 0;
  int hCnt = 0;
  int fails = 0;
  int cmpCount = 0;
  // Rows: mode, parity, data, stored, address event, mode after
  logic [16:0] rows [10] = '{17'h0_0670, 17'h0_8662, 17'h0_C663, 17'h0_F4BB, 17'h0_4671,
    17'h1_74AF, 17'h1_EB5D, 17'h1_C667, 17'h1_4675, 17'h1_F4AF};
  logic [16:0] r;
  wire txHoldValid = hIdx < hCnt;
  wire [7:0] txHoldData = hold[hIdx % 5];
  always #50 clk_sys = ~clk_sys;
  // Pop the holding buffer when the gate takes a character
  always @(negedge clk_sys) if (txHoldTake) hIdx <= hIdx + 1;
  utg_top u_utg_top (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .regReq(regReq),
    .regRdata(regRdata),
    .txHoldValid(txHoldValid),
    .txHoldData(txHoldData),
    .txHoldTake(txHoldTake),
    .txShiftBusy(txShiftBusy),
    .txShiftLoad(txShiftLoad),
    .txShiftData(txShiftData),
    .rxValid(rxValid),
    .rxChar(rxChar),
    .rxFifoWrite(rxFifoWrite),
    .rxFifoData(rxFifoData),
    .rxDataReadyEvent(rxDataReadyEvent),
    .addressEvent(addressEvent),
    .transmitPermit(transmitPermit),
    .multidropCtrl(multidropCtrl)
  );
  utg_shifter_model u_utg_shifter_model (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .txShiftLoad(txShiftLoad),
    .txShiftData(txShiftData),
    .slow(slow),
    .txShiftBusy(txShiftBusy),
    .sentWord(sentWord),
    .sentCount(sentCount)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmpCount++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One register cycle, held for a full clock
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    regReq = '{w, !w, a, d};
    @(negedge clk_sys);
    regReq = '0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(regRdata, e);
  endtask
  // Bounded wait for the shifter to have taken n characters
  task automatic waitSent(input logic [3:0] n);
    for (int i = 0; i < 200 && sentCount != n; i++) @(negedge clk_sys);
  endtask
  task automatic stop_test;
    if (fails == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    stop_test;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    chk({transmitPermit, multidropCtrl}, 4'h8);
    rd(utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0080);
    rd(utg_pkg::MULTIDROP_CTRL_ADDR, 32'h0000_0000);
    rd(32'h4000_8040, 32'h0000_0000);
    bus(1'b1, utg_pkg::ADDR_MATCH_ADDR, 32'h0000_005A);
    // Each row: set the mode, send one character, check fate and mode
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, utg_pkg::MULTIDROP_CTRL_ADDR, {29'h0, r[16:14]});
      rxValid = 1'b1;
      rxChar = r[13:5];
      @(negedge clk_sys);
      rxValid = 1'b0;
      chk(rxFifoWrite, r[4]);
      chk(addressEvent, r[3]);
      chk(rxDataReadyEvent, r[4]);
      if (r[4]) chk(rxFifoData, r[13:5]);
      rd(utg_pkg::MULTIDROP_CTRL_ADDR, {29'h0, r[2:0]});
      chk(multidropCtrl, r[2:0]);
    end
    // Back-to-back characters with a prompt shifter keep their order
    hCnt = 3;
    waitSent(4'h3);
    chk(sentWord[23:0], 24'h11_2233);
    // Clear the permit while a slow character is on the wire
    slow = 1'b1;
    hCnt = 5;
    waitSent(4'h4);
    bus(1'b1, utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0000);
    repeat (40) @(negedge clk_sys);
    chk({txShiftBusy, sentCount}, 5'h04);
    chk(transmitPermit, 1'b0);
    rd(utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0000);
    bus(1'b1, utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0080);
    waitSent(4'h5);
    chk(sentWord[7:0], 8'h55);
    // Reset in mid-run with modes and permit away from their reset values
    bus(1'b1, utg_pkg::MULTIDROP_CTRL_ADDR, 32'h0000_0007);
    bus(1'b1, utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0000);
    @(negedge clk_sys);
    chk({transmitPermit, multidropCtrl}, 4'h7);
    rstn = 1'b0;
    @(negedge clk_sys);
    rstn = 1'b1;
    chk({transmitPermit, multidropCtrl}, 4'h8);
    rd(utg_pkg::TX_PERMIT_CTRL_ADDR, 32'h0000_0080);
    rd(utg_pkg::MULTIDROP_CTRL_ADDR, 32'h0000_0000);
    stop_test;
  end
endmodule
bind utg_top utg_monitor u_utg_monitor (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .txHoldValid(txHoldValid),
  .txHoldData(txHoldData),
  .txHoldTake(txHoldTake),
  .txShiftBusy(txShiftBusy),
  .txShiftLoad(txShiftLoad),
  .txShiftData(txShiftData),
  .transmitPermit(transmitPermit),
  .rxValid(rxValid),
  .rxChar(rxChar),
  .rxFifoWrite(rxFifoWrite),
  .rxFifoData(rxFifoData),
  .rxDataReadyEvent(rxDataReadyEvent),
  .addressEvent(addressEvent),
  .multidropCtrl(multidropCtrl)
);
